// ==== design/lsc_defs.vh ====
// Purpose: shared constants of the low-speed oscillator and system clock select block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by its bare name by the divider and clock control design files of the block
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH

// ********************************
// register byte addresses
// ********************************
`define LSC_ADDR_W              12
`define LSC_OFS_CLOCK_SELECT    12'h000
`define LSC_OFS_SLOW_XTAL_CTRL  12'h004
`define LSC_OFS_FAST_OSC_CTRL   12'h008
`define LSC_OFS_PIN_CTRL        12'h00c

// ********************************
// clock_select_reg fields
// ********************************
`define LSC_SYSSEL_HI           7
`define LSC_SYSSEL_LO           5
`define LSC_HFSEL_BIT           3
`define LSC_LFSEL_BIT           2
`define LSC_HIDLE_BIT           1
`define LSC_LIDLE_BIT           0
`define LSC_CLOCK_SELECT_RST    8'h00
`define LSC_SYSSEL_FULL         3'h0
`define LSC_SYSSEL_LOW          3'h7

// ********************************
// slow_crystal_ctrl_reg fields
// ********************************
`define LSC_SPEEDUP_BIT         2
`define LSC_STABLE_BIT          1
`define LSC_ENABLE_BIT          0
`define LSC_SLOW_XTAL_RST       3'h0

// ********************************
// fast oscillator and pin control fields
// ********************************
`define LSC_HS_KEEP_BIT         0
`define LSC_FAST_OSC_RST        1'h1
`define LSC_PIN_A_IO_BIT        0
`define LSC_PIN_B_IO_BIT        1
`define LSC_PIN_CTRL_RST        2'h0

// ********************************
// timing
// ********************************
`define LSC_PCLK_MHZ            200
`define LSC_STARTUP_SPEEDUP_US  1000
`define LSC_STARTUP_LOWPOWER_US 2000
`define LSC_DIV_STAGES          7
`define LSC_DIV_CNT_W           6

`endif

// ==== design/lsc_divider.v ====
// Purpose: ripple-free prescaler producing high_speed_clock divided by 1 to 64 as ticks
// Assumes: tick_in is a one-cycle pulse per high-speed clock edge, synchronous to pclk
// Notes:   div_tick[k] pulses once every 2**k input ticks; all outputs are registered
`include "lsc_defs.vh"
`default_nettype none

module lsc_divider #(
    parameter STAGES = `LSC_DIV_STAGES,
    parameter CNT_W  = `LSC_DIV_CNT_W
) (
    // clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // tick in and divided ticks out
    input  wire              tick_in,
    output reg  [STAGES-1:0] div_tick
);

    reg  [CNT_W-1:0]  count;
    wire [CNT_W-1:0]  next_count;
    wire [STAGES-1:0] next_div_tick;

    assign next_count = tick_in ? count + {{(CNT_W-1){1'b0}}, 1'b1} : count;

    // ********************************
    // one decode per stage
    // ********************************
    assign next_div_tick[0] = tick_in;
    genvar k;
    generate
        for (k = 1; k < STAGES; k = k + 1) begin : g_stage
            // a stage fires on the tick that rolls its low k bits over
            assign next_div_tick[k] = tick_in & (&count[k-1:0]);
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= {CNT_W{1'b0}};
            div_tick <= {STAGES{1'b0}};
        end else begin
            count    <= next_count;
            div_tick <= next_div_tick;
        end
    end

endmodule // lsc_divider

`default_nettype wire

// ==== design/lsc_clock_ctrl.v ====
// Purpose: low-speed oscillator control and system clock selection behind an APB slave
// Assumes: oscillator activity arrives as one-cycle ticks synchronous to pclk
// Notes:   clocks leave the block as tick pulses; one wait state on every APB access
`include "lsc_defs.vh"
`default_nettype none

module lsc_clock_ctrl #(
    parameter SPEEDUP_CYCLES  = `LSC_STARTUP_SPEEDUP_US * `LSC_PCLK_MHZ,
    parameter LOWPOWER_CYCLES = `LSC_STARTUP_LOWPOWER_US * `LSC_PCLK_MHZ,
    parameter CNT_W           = 20
) (
    // clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // apb slave
    input  wire [`LSC_ADDR_W-1:0] paddr,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [31:0]            pwdata,
    output reg                    pready,
    output reg  [31:0]            prdata,
    output reg                    pslverr,
    // oscillator activity ticks
    input  wire                   slow_crystal_osc_tick,
    input  wire                   internal_slow_rc_osc_tick,
    input  wire                   fast_crystal_osc_tick,
    input  wire                   internal_fast_rc_osc_tick,
    // system state
    input  wire                   cpu_halt,
    input  wire                   watchdog_enable,
    // oscillator controls
    output reg                    slow_crystal_osc_run,
    output reg                    slow_crystal_speedup,
    output reg                    internal_slow_rc_osc_run,
    output reg                    fast_crystal_osc_run,
    output reg                    internal_fast_rc_osc_run,
    // slow crystal pin sharing
    output reg                    slow_crystal_pin_a_is_osc,
    output reg                    slow_crystal_pin_b_is_osc,
    // clock ticks
    output reg                    low_speed_clock,
    output reg                    high_speed_clock,
    output reg  [`LSC_DIV_STAGES-1:0] high_speed_div_clock,
    output reg                    system_clock,
    output reg                    watchdog_clock,
    output reg                    time_base_clock
);

    // ********************************
    // startup counter states
    // ********************************
    localparam ST_OFF    = 3'b001;
    localparam ST_START  = 3'b010;
    localparam ST_STABLE = 3'b100;

    localparam [CNT_W-1:0] SPEEDUP_LOAD  = SPEEDUP_CYCLES[CNT_W-1:0] - 1'b1;
    localparam [CNT_W-1:0] LOWPOWER_LOAD = LOWPOWER_CYCLES[CNT_W-1:0] - 1'b1;

    // slow crystal counts as used when enabled, or chosen as low-speed source
    function slow_xtal_used;
        input en;
        input lfsel;
        begin
            slow_xtal_used = en | lfsel;
        end
    endfunction

    // ********************************
    // registers
    // ********************************
    reg [2:0]       system_clock_sel;
    reg             high_freq_source_sel;
    reg             low_freq_source_sel;
    reg             high_idle_enable;
    reg             low_idle_enable;
    reg             slow_crystal_enable;
    reg             slow_crystal_speedup_sel;
    reg             high_speed_keep;
    reg             pin_a_io_req;
    reg             pin_b_io_req;
    reg [2:0]       xtal_state;
    reg [CNT_W-1:0] xtal_count;

    reg [2:0]       next_xtal_state;
    reg [CNT_W-1:0] next_xtal_count;
    reg [31:0]      next_prdata;
    reg             addr_ok;

    wire access  = psel & penable & ~pready;
    wire wr_done = psel & penable & pready & pwrite & ~pslverr;
    wire slow_stable = (xtal_state == ST_STABLE);
    wire low_is_sys  = (system_clock_sel == `LSC_SYSSEL_LOW);
    wire xtal_is_sys = low_is_sys & low_freq_source_sel;

    // ********************************
    // apb slave
    // ********************************
    always @* begin
        addr_ok     = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `LSC_OFS_CLOCK_SELECT: begin
                next_prdata[`LSC_SYSSEL_HI:`LSC_SYSSEL_LO] = system_clock_sel;
                next_prdata[`LSC_HFSEL_BIT] = high_freq_source_sel;
                next_prdata[`LSC_LFSEL_BIT] = low_freq_source_sel;
                next_prdata[`LSC_HIDLE_BIT] = high_idle_enable;
                next_prdata[`LSC_LIDLE_BIT] = low_idle_enable;
            end
            `LSC_OFS_SLOW_XTAL_CTRL: begin
                next_prdata[`LSC_SPEEDUP_BIT] = slow_crystal_speedup_sel;
                next_prdata[`LSC_STABLE_BIT]  = slow_stable;
                next_prdata[`LSC_ENABLE_BIT]  = slow_crystal_enable;
            end
            `LSC_OFS_FAST_OSC_CTRL: begin
                next_prdata[`LSC_HS_KEEP_BIT] = high_speed_keep;
            end
            `LSC_OFS_PIN_CTRL: begin
                next_prdata[`LSC_PIN_A_IO_BIT] = pin_a_io_req;
                next_prdata[`LSC_PIN_B_IO_BIT] = pin_b_io_req;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // one wait state so read data and error can come out of flops
            pready  <= access;
            pslverr <= access & ~addr_ok;
            if (access && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_sel         <= `LSC_SYSSEL_FULL;
            high_freq_source_sel     <= 1'b0;
            low_freq_source_sel      <= 1'b0;
            high_idle_enable         <= 1'b0;
            low_idle_enable          <= 1'b0;
            slow_crystal_enable      <= 1'b0;
            slow_crystal_speedup_sel <= 1'b0;
            high_speed_keep          <= `LSC_FAST_OSC_RST;
            pin_a_io_req             <= 1'b0;
            pin_b_io_req             <= 1'b0;
        end else if (wr_done) begin
            case (paddr)
                `LSC_OFS_CLOCK_SELECT: begin
                    system_clock_sel     <= pwdata[`LSC_SYSSEL_HI:`LSC_SYSSEL_LO];
                    high_freq_source_sel <= pwdata[`LSC_HFSEL_BIT];
                    low_freq_source_sel  <= pwdata[`LSC_LFSEL_BIT];
                    high_idle_enable     <= pwdata[`LSC_HIDLE_BIT];
                    low_idle_enable      <= pwdata[`LSC_LIDLE_BIT];
                end
                `LSC_OFS_SLOW_XTAL_CTRL: begin
                    slow_crystal_enable <= pwdata[`LSC_ENABLE_BIT];
                    // mode is frozen while the crystal feeds the system clock
                    if (!xtal_is_sys) begin
                        slow_crystal_speedup_sel <= pwdata[`LSC_SPEEDUP_BIT];
                    end
                end
                `LSC_OFS_FAST_OSC_CTRL: begin
                    high_speed_keep <= pwdata[`LSC_HS_KEEP_BIT];
                end
                `LSC_OFS_PIN_CTRL: begin
                    pin_a_io_req <= pwdata[`LSC_PIN_A_IO_BIT];
                    pin_b_io_req <= pwdata[`LSC_PIN_B_IO_BIT];
                end
                default: begin
                    high_speed_keep <= high_speed_keep;
                end
            endcase
        end
    end

    // ********************************
    // slow crystal start-up
    // ********************************
    always @* begin
        next_xtal_state = xtal_state;
        next_xtal_count = xtal_count;
        case (xtal_state)
            ST_OFF: begin
                if (slow_crystal_enable) begin
                    next_xtal_state = ST_START;
                    // low-power start is slower; running behaviour is identical
                    next_xtal_count = slow_crystal_speedup_sel ? SPEEDUP_LOAD
                                                               : LOWPOWER_LOAD;
                end
            end
            ST_START: begin
                if (!slow_crystal_enable) begin
                    next_xtal_state = ST_OFF;
                end else if (xtal_count == {CNT_W{1'b0}}) begin
                    next_xtal_state = ST_STABLE;
                end else begin
                    next_xtal_count = xtal_count - 1'b1;
                end
            end
            ST_STABLE: begin
                // a later switch to low-power leaves the crystal running
                if (!slow_crystal_enable) begin
                    next_xtal_state = ST_OFF;
                end
            end
            default: begin
                next_xtal_state = ST_OFF;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_state <= ST_OFF;
            xtal_count <= {CNT_W{1'b0}};
        end else begin
            xtal_state <= next_xtal_state;
            xtal_count <= next_xtal_count;
        end
    end

    // ********************************
    // clock sources and selection
    // ********************************
    wire [`LSC_DIV_STAGES-1:0] div_tick;
    wire hs_on    = cpu_halt ? high_idle_enable : (~low_is_sys | high_speed_keep);
    wire ls_on    = ~cpu_halt | low_idle_enable;
    wire hs_src   = high_freq_source_sel ? fast_crystal_osc_tick
                                         : internal_fast_rc_osc_tick;
    wire hs_tick  = hs_on & hs_src;
    // gated until start-up has ended so no early edges leak out
    wire xt_tick  = slow_stable & slow_crystal_osc_tick;
    wire ls_tick  = low_freq_source_sel ? xt_tick : internal_slow_rc_osc_tick;
    wire sys_tick = low_is_sys ? ls_tick
                               : div_tick[system_clock_sel];

    lsc_divider #(
        .STAGES (`LSC_DIV_STAGES),
        .CNT_W  (`LSC_DIV_CNT_W)
    ) u_divider (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_in  (hs_tick),
        .div_tick (div_tick)
    );

    // divider adds one cycle; the low-speed path is delayed to match
    reg ls_tick_d;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_tick_d                 <= 1'b0;
            low_speed_clock           <= 1'b0;
            high_speed_clock          <= 1'b0;
            high_speed_div_clock      <= {`LSC_DIV_STAGES{1'b0}};
            system_clock              <= 1'b0;
            watchdog_clock            <= 1'b0;
            time_base_clock           <= 1'b0;
            slow_crystal_osc_run      <= 1'b0;
            slow_crystal_speedup      <= 1'b0;
            internal_slow_rc_osc_run  <= 1'b0;
            fast_crystal_osc_run      <= 1'b0;
            internal_fast_rc_osc_run  <= 1'b0;
            slow_crystal_pin_a_is_osc <= 1'b0;
            slow_crystal_pin_b_is_osc <= 1'b0;
        end else begin
            ls_tick_d            <= ls_tick;
            low_speed_clock      <= ls_tick_d & ls_on;
            high_speed_clock     <= div_tick[0];
            high_speed_div_clock <= div_tick;
            // halt always gates the processor clock; the other clocks stop only as the idle and watchdog enables allow
            system_clock         <= ~cpu_halt & (low_is_sys ? ls_tick_d : sys_tick);
            watchdog_clock       <= ls_tick_d & (ls_on | watchdog_enable);
            time_base_clock      <= ls_tick_d & ls_on;
            slow_crystal_osc_run <= slow_crystal_enable;
            slow_crystal_speedup <= slow_crystal_speedup_sel;
            internal_slow_rc_osc_run <= (~low_freq_source_sel & ls_on) | watchdog_enable;
            fast_crystal_osc_run     <= hs_on & high_freq_source_sel;
            internal_fast_rc_osc_run <= hs_on & ~high_freq_source_sel;
            slow_crystal_pin_a_is_osc <=
                slow_xtal_used(slow_crystal_enable, low_freq_source_sel) | ~pin_a_io_req;
            slow_crystal_pin_b_is_osc <=
                slow_xtal_used(slow_crystal_enable, low_freq_source_sel) | ~pin_b_io_req;
        end
    end

endmodule // lsc_clock_ctrl

`default_nettype wire

// ==== design/lsc_clock_ctrl_pad.v ====
// Purpose: none
// Assumes: none
// Notes:   none
`default_nettype none
`default_nettype wire

// ==== dv/lsc_clock_ctrl_chk.sv ====
// Purpose: assertions on the clock and oscillator outputs of lsc_clock_ctrl
// Assumes: oscillator ticks reach the clock outputs two cycles later
// Notes:   bound into every instance of the block
`include "lsc_defs.vh"
`default_nettype none

module lsc_clock_ctrl_chk (
    // clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // inputs watched
    input wire logic                       cpu_halt,
    input wire logic                       slow_crystal_osc_tick,
    input wire logic                       internal_slow_rc_osc_tick,
    input wire logic                       fast_crystal_osc_tick,
    input wire logic                       internal_fast_rc_osc_tick,
    // outputs watched
    input wire logic                       fast_crystal_osc_run,
    input wire logic                       internal_fast_rc_osc_run,
    input wire logic                       slow_crystal_osc_run,
    input wire logic                       slow_crystal_pin_a_is_osc,
    input wire logic                       low_speed_clock,
    input wire logic                       high_speed_clock,
    input wire logic [`LSC_DIV_STAGES-1:0] high_speed_div_clock,
    input wire logic                       system_clock,
    input wire logic                       watchdog_clock,
    input wire logic                       time_base_clock
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_HALT_GATES_SYS: assert property (cpu_halt [*3] |-> !system_clock)
        else $error("system clock ticked while halted");
    AST_DIV_ONE_IS_FULL: assert property (high_speed_div_clock[0] == high_speed_clock)
        else $error("undivided tick differs from high-speed clock");
    AST_DIV_NESTED: assert property ((high_speed_div_clock & ~{high_speed_div_clock[5:0], 1'b1}) == 7'h00)
        else $error("divided tick without the faster stage");
    AST_TIME_BASE_LOW: assert property (time_base_clock == low_speed_clock)
        else $error("time base clock differs from low-speed clock");
    AST_WDOG_LOW: assert property (low_speed_clock |-> watchdog_clock)
        else $error("watchdog missed a low-speed tick");
    AST_LOW_SOURCE: assert property (low_speed_clock |->
        $past(slow_crystal_osc_tick, 2) || $past(internal_slow_rc_osc_tick, 2))
        else $error("low-speed tick without a slow oscillator tick");
    AST_HIGH_SOURCE: assert property (high_speed_clock |->
        $past(fast_crystal_osc_tick, 2) || $past(internal_fast_rc_osc_tick, 2))
        else $error("high-speed tick without a fast oscillator tick");
    AST_ONE_FAST_OSC: assert property (!(fast_crystal_osc_run && internal_fast_rc_osc_run))
        else $error("both fast oscillators running");
    AST_PIN_IO_XTAL_OFF: assert property (!slow_crystal_pin_a_is_osc [*2] |-> !slow_crystal_osc_run)
        else $error("crystal runs while its pin is general I/O");
    AST_SYS_FROM_SOURCE: assert property (system_clock |-> high_speed_clock || low_speed_clock)
        else $error("system tick with no source tick");

    cover property (cpu_halt && watchdog_clock);
    cover property (high_speed_div_clock[6]);
    cover property (fast_crystal_osc_run && high_speed_clock);
endmodule // lsc_clock_ctrl_chk

bind lsc_clock_ctrl lsc_clock_ctrl_chk lsc_clock_ctrl_chk_i (
    .pclk, .presetn, .cpu_halt, .slow_crystal_osc_tick, .internal_slow_rc_osc_tick,
    .fast_crystal_osc_tick, .internal_fast_rc_osc_tick, .fast_crystal_osc_run,
    .internal_fast_rc_osc_run, .slow_crystal_osc_run, .slow_crystal_pin_a_is_osc,
    .low_speed_clock, .high_speed_clock, .high_speed_div_clock, .system_clock,
    .watchdog_clock, .time_base_clock
);
`default_nettype wire

// ==== dv/lsc_osc_model.sv ====
// Purpose: behavioural oscillators feeding ticks to the clock control block
// Assumes: index 0 slow crystal, 1 slow rc, 2 fast crystal, 3 fast rc
// Notes:   an oscillator whose run input is low gives no ticks at all
`default_nettype none

module lsc_osc_model #(
    parameter int PER_SX = 7,
    parameter int PER_SR = 11,
    parameter int PER_FX = 5,
    parameter int PER_FR = 3
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // run requests and ticks
    input  wire logic [3:0] run,
    output var  logic [3:0] tick
);
    localparam int PER [4] = '{PER_SX, PER_SR, PER_FX, PER_FR};
    int cnt [4];

    // crystal oscillates whatever its mode bit once enabled
    always @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < 4; i++) begin
            if (!presetn || !run[i]) begin
                cnt[i] <= 0;
                tick[i] <= 1'b0;
            end else begin
                cnt[i] <= (cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
                tick[i] <= (cnt[i] == PER[i] - 1);
            end
        end
    end
endmodule // lsc_osc_model
`default_nettype wire

// ==== dv/low_speed_osc_and_sysclk_select_tb.sv ====
// Purpose: self-checking bench of the slow oscillator and system clock select block
// Assumes: oscillator periods 7, 11, 5 and 3 cycles from lsc_osc_model
// Notes:   start-up counts shortened so the run stays brief
`default_nettype none

module low_speed_osc_and_sysclk_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPEEDUP = 16;
    localparam int LOWPOWER = 48;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        cpu_halt = 1'b0, watchdog_enable = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    wire  [31:0] prdata;
    wire  [3:0]  run, tick, cv;
    wire         pready, pslverr, sx_speedup, pin_a, pin_b;
    int          failures = 0, compares = 0, g;

    lsc_clock_ctrl #(.SPEEDUP_CYCLES(SPEEDUP), .LOWPOWER_CYCLES(LOWPOWER)) lsc_clock_ctrl_i (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .slow_crystal_osc_tick(tick[0]), .internal_slow_rc_osc_tick(tick[1]),
        .fast_crystal_osc_tick(tick[2]), .internal_fast_rc_osc_tick(tick[3]),
        .cpu_halt, .watchdog_enable, .slow_crystal_osc_run(run[0]),
        .slow_crystal_speedup(sx_speedup), .internal_slow_rc_osc_run(run[1]),
        .fast_crystal_osc_run(run[2]), .internal_fast_rc_osc_run(run[3]),
        .slow_crystal_pin_a_is_osc(pin_a), .slow_crystal_pin_b_is_osc(pin_b),
        .low_speed_clock(cv[1]), .high_speed_clock(cv[0]), .high_speed_div_clock(),
        .system_clock(cv[2]), .watchdog_clock(cv[3]), .time_base_clock());
    lsc_osc_model lsc_osc_model_i (.pclk, .presetn, .run, .tick);

    initial forever #2.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // settle lets the two-cycle tick pipeline flush the old setting
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (4) @(posedge pclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // cycles between two pulses of cv[i]; 400 means none seen
    task automatic gap(input int i, input int exp);
        int n;
        n = 0;
        g = 0;
        do begin @(posedge pclk); n++; end while (cv[i] !== 1'b1 && n < 400);
        do begin @(posedge pclk); g++; end while (cv[i] !== 1'b1 && g < 400);
        chk(g, exp);
    endtask

    task automatic s_reset;
        rdc(12'h000, 32'h0);
        rdc(12'h004, 32'h0);
        rdc(12'h008, 32'h1);
        rdc(12'h00c, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(run, 4'b1010);
        gap(0, 3);
        gap(1, 11);
    endtask

    task automatic s_sysdiv;
        int r, n;
        for (int k = 0; k < 7; k++) begin
            wr(12'h000, k << 5);
            n = 0;
            r = 0;
            do begin @(posedge pclk); n++; end while (cv[2] !== 1'b1 && n < 400);
            do begin @(posedge pclk); r += cv[0]; n++; end while (cv[2] !== 1'b1 && n < 800);
            chk(r, 1 << k);
        end
        wr(12'h000, 32'he0);
        gap(2, 11);
        wr(12'h000, 32'h08);
        chk(run[3:2], 2'b01);
        gap(0, 5);
    endtask

    task automatic s_slow;
        wr(12'h004, 32'h5);
        chk({run[0], sx_speedup}, 2'b11);
        rdc(12'h004, 32'h5);
        repeat (20) @(posedge pclk);
        rdc(12'h004, 32'h7);
        wr(12'h004, 32'h0);
        wr(12'h004, 32'h1);
        chk({run[0], sx_speedup}, 2'b10);
        repeat (20) @(posedge pclk);
        rdc(12'h004, 32'h1);
        repeat (30) @(posedge pclk);
        rdc(12'h004, 32'h3);
        wr(12'h000, 32'h04);
        chk(run[1], 1'b0);
        gap(1, 7);
    endtask

    task automatic s_lock;
        wr(12'h004, 32'h5);
        wr(12'h000, 32'he4);
        wr(12'h004, 32'h1);
        rdc(12'h004, 32'h7);
        chk(sx_speedup, 1'b1);
        gap(2, 7);
        wr(12'h000, 32'h04);
        wr(12'h004, 32'h1);
        rdc(12'h004, 32'h3);
        chk({run[0], sx_speedup}, 2'b10);
    endtask

    task automatic s_halt;
        wr(12'h000, 32'he4);
        wr(12'h008, 32'h0);
        chk(run[3:2], 2'b00);
        wr(12'h008, 32'h1);
        chk(run[3:2], 2'b10);
        cpu_halt <= 1'b1;
        wr(12'h000, 32'h04);
        chk(run[3:2], 2'b00);
        gap(2, 400);
        gap(1, 400);
        watchdog_enable <= 1'b1;
        gap(3, 7);
        wr(12'h000, 32'h05);
        gap(1, 7);
        wr(12'h000, 32'h06);
        chk(run[3:2], 2'b10);
        gap(0, 3);
        {cpu_halt, watchdog_enable} <= 2'b00;
    endtask

    task automatic s_pins;
        wr(12'h00c, 32'h3);
        chk({pin_a, pin_b}, 2'b11);
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h00);
        chk({pin_a, pin_b}, 2'b00);
        wr(12'h00c, 32'h0);
        chk({pin_a, pin_b}, 2'b11);
    endtask

    task automatic conclude;
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_sysdiv();
        s_slow();
        s_lock();
        s_halt();
        s_pins();
        conclude();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        conclude();
    end
endmodule // low_speed_osc_and_sysclk_select_tb
`default_nettype wire
